/* File: logic/psf_pkg.sv */
/*
 * psf_pkg: constants, types and register map of the process status and
 * fault select block.
 * assumes: one 25 MHz clock; AHB-Lite register access, word aligned.
 */
package psf_pkg;

   // register byte offsets
   localparam logic [7:0] PSF_OFF_STATUS = 8'h00;
   localparam logic [7:0] PSF_OFF_PID = 8'h04;
   localparam logic [7:0] PSF_OFF_LENGTH = 8'h08;
   localparam logic [7:0] PSF_OFF_OBJIDX = 8'h0c;
   localparam logic [7:0] PSF_OFF_DOMAIN = 8'h10;
   localparam logic [7:0] PSF_OFF_FUNC = 8'h14;
   localparam logic [7:0] PSF_OFF_CTRL = 8'h18;
   localparam logic [7:0] PSF_OFF_INFO = 8'h1c;

   // process status field bit positions
   localparam int PSF_ST_BOUND = 0;
   localparam int PSF_ST_CTXF = 1;
   localparam int PSF_ST_PROCF = 2;
   localparam int PSF_ST_READY = 3;
   localparam int PSF_ST_FVEC = 4;

   // process id: upper 14 bits id, lower 2 bits forced zero
   localparam int PSF_PID_LO_W = 2;

   // object index: low subfield is the entered segment index
   localparam int PSF_IDX_ENT_W = 2;

   // func register fields
   localparam int PSF_FUNC_GO = 16;

   // ctrl register fields
   localparam int PSF_CTRL_REL21 = 0;
   localparam int PSF_CTRL_FACK = 1;
   localparam int PSF_CTRL_CLRERR = 2;

   // reset values
   localparam logic [15:0] PSF_STATUS_RST = 16'h0000;
   localparam logic [15:0] PSF_PID_RST = 16'h0000;
   localparam logic [31:0] PSF_WORD_RST = 32'h0000_0000;

   // fault record placement; one record layout for all three areas
   localparam logic [15:0] PSF_CTX_AREA_BASE = 16'h0040;
   localparam logic [15:0] PSF_PROC_AREA_BASE = 16'h0060;
   localparam logic [15:0] PSF_CPU_AREA_BASE = 16'h0080;

   typedef enum logic [1:0] {
      PSF_SEV_NONE = 2'h0,
      PSF_SEV_CTX = 2'h1,
      PSF_SEV_PROC = 2'h2,
      PSF_SEV_CPU = 2'h3
   } psf_sev_t;

   typedef enum logic [2:0] {
      PSF_S_IDLE = 3'b001,
      PSF_S_BUSY = 3'b010,
      PSF_S_HALT = 3'b100
   } psf_state_t;

   typedef struct packed {
      psf_sev_t sev;
      psf_sev_t handling;
      logic bound;
      logic ctx_faulted;
      logic fvec;
      logic rel21;
   } psf_fault_in_t;

   typedef struct packed {
      psf_sev_t eff_sev;
      psf_sev_t area;
   } psf_fault_out_t;

endpackage

/* File: logic/psf_fault_sel.sv */
/*
 * psf_fault_sel: combinational severity resolution and fault area choice.
 * assumes: state inputs are registered in the top module; sev comes straight from the fault ports.
 */
`timescale 1ns/1ps

module psf_fault_sel (
   // fault raised plus process state
   input wire psf_pkg::psf_fault_in_t i_req,
   // resolved severity and target area
   output psf_pkg::psf_fault_out_t o_res
);
   import psf_pkg::*;

   psf_sev_t sev_v;

   always_comb begin
      sev_v = i_req.sev;
      // later revision: fault vector makes process faults context faults, or processor faults if the context faulted
      if (i_req.rel21 && i_req.fvec && sev_v == PSF_SEV_PROC) begin
         sev_v = i_req.ctx_faulted ? PSF_SEV_CPU : PSF_SEV_CTX;
      end
      // a fault during fault handling rises to at least one level above the level handled, or stays processor while a processor fault is handled
      if (sev_v != PSF_SEV_NONE) begin
         if (i_req.handling == PSF_SEV_CTX && sev_v == PSF_SEV_CTX) begin
            sev_v = PSF_SEV_PROC;
         end else if (i_req.handling == PSF_SEV_PROC) begin
            sev_v = PSF_SEV_CPU;
         end else if (i_req.handling == PSF_SEV_CPU) begin
            sev_v = PSF_SEV_CPU;
         end
      end
      // context faults only exist while bound
      if (sev_v == PSF_SEV_CTX && !i_req.bound) begin
         sev_v = PSF_SEV_PROC;
      end
      o_res.eff_sev = sev_v;
      o_res.area = sev_v;
      if (sev_v == PSF_SEV_PROC) begin
         // bound: process area, else processor area
         o_res.area = i_req.bound ? PSF_SEV_PROC : PSF_SEV_CPU;
      end
   end

endmodule

/* File: logic/psf_top.sv */
/*
 * psf_top: process status interpretation, object field decode, function
 * request gating and fault area selection, with an AHB-Lite register file.
 * assumes: single master, single slave (hreadyout is hready), word
 * transfers only; function engine and fault sources are on-chip logic.
 */
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

// Operation
// - a stored length of n means n plus one bytes.
// - object index decode drops the entered segment subfield and keeps the displacement.
// - the defining domain descriptor is stored and returned untouched.
// - only the combined status bits are interpreted, other status bits are opaque.
// - the bound bit is 1 while attached to the processor and 0 otherwise.
// - context and process faulted bits are 1 once that level faulted, else 0.
// - functions are accepted only while the ready bit is 1.
// - the process id lives in the upper 14 bits and the low 2 bits stay zero.
// - all three fault areas share one record layout at their own base.
// - a process fault while bound goes to the process fault area.
// - a process fault while unbound goes to the processor fault area.
// - with the later revision and fault vector set, process faults become context faults, or processor faults if the context already faulted.
// - functions run one at a time, a request while busy is refused.
// - a request from a different host process switches the exposed environment.
// - a fault while handling a context fault is treated as a process fault.
module psf_top (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // attachment events from the dispatcher
   input wire logic i_attach,
   input wire logic i_detach,
   // function engine
   input wire logic i_func_done,
   output logic o_func_start,
   output logic [15:0] o_func_host,
   output logic o_env_switch,
   output logic [15:0] o_proc_id,
   // fault sources and fault record writer
   input wire logic i_fault_valid,
   input wire psf_pkg::psf_sev_t i_fault_sev,
   output logic o_fault_wr,
   output psf_pkg::psf_sev_t o_fault_area,
   output logic [15:0] o_fault_base,
   output logic o_fatal,
   // status view
   output logic o_bound,
   output logic o_busy
);
   import psf_pkg::*;

   function automatic logic [16:0] len_decode(input logic [15:0] raw);
      len_decode = {1'b0, raw} + 17'h0_0001;
   endfunction

   function automatic logic [15:0] area_base(input psf_sev_t area);
      case (area)
         PSF_SEV_CTX: area_base = PSF_CTX_AREA_BASE;
         PSF_SEV_PROC: area_base = PSF_PROC_AREA_BASE;
         PSF_SEV_CPU: area_base = PSF_CPU_AREA_BASE;
         default: area_base = 16'h0000;
      endcase
   endfunction

   // bus state
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;

   // register file
   logic [15:0] status_reg;
   logic [15:0] pid_reg;
   logic [15:0] length_reg;
   logic [15:0] objidx_reg;
   logic [31:0] domain_reg;
   logic rel21_reg;
   logic refused_reg;

   // function and fault state
   psf_state_t state_reg;
   psf_state_t state_next;
   logic [15:0] host_reg;
   logic host_valid_reg;
   logic func_start_reg;
   logic env_switch_reg;
   psf_sev_t handling_reg;
   logic busy_reg;
   logic fault_wr_reg;
   psf_sev_t fault_area_reg;
   logic [15:0] fault_base_reg;
   logic fatal_reg;

   logic addr_ok;
   logic wr_now;
   logic func_wr;
   logic func_go;
   logic func_ok;
   logic fack_wr;
   logic clrerr_wr;
   psf_fault_in_t fin;
   psf_fault_out_t fout;
   logic [31:0] rd_mux;

   assign addr_ok = i_hsel && i_htrans[1] && i_hready;
   assign wr_now = wr_pend_reg;
   assign func_wr = wr_now && addr_reg == PSF_OFF_FUNC;
   assign func_go = func_wr && i_hwdata[PSF_FUNC_GO];
   // refused while busy, halted, handling a fault or not ready
   assign func_ok = func_go && state_reg == PSF_S_IDLE
      && status_reg[PSF_ST_READY]
      && handling_reg == PSF_SEV_NONE;
   assign fack_wr = wr_now && addr_reg == PSF_OFF_CTRL
      && i_hwdata[PSF_CTRL_FACK];
   assign clrerr_wr = wr_now && addr_reg == PSF_OFF_CTRL
      && i_hwdata[PSF_CTRL_CLRERR];

   // bus front end; reads take one wait so a write just before is seen
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         wr_pend_reg <= 1'b0;
         if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
         end else if (addr_ok) begin
            addr_reg <= {i_haddr[7:2], 2'b00};
            wr_pend_reg <= i_hwrite;
            rd_pend_reg <= !i_hwrite;
            hreadyout_reg <= i_hwrite;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (addr_reg)
         PSF_OFF_STATUS: rd_mux = {16'h0000, status_reg};
         PSF_OFF_PID: rd_mux = {16'h0000, pid_reg};
         PSF_OFF_LENGTH: rd_mux = {15'h0000, len_decode(length_reg)};
         // displacement only, entered segment subfield dropped
         PSF_OFF_OBJIDX: rd_mux = {18'h0_0000,
            objidx_reg[15:PSF_IDX_ENT_W]};
         PSF_OFF_DOMAIN: rd_mux = domain_reg;
         PSF_OFF_FUNC: rd_mux = {15'h0000, host_valid_reg, host_reg};
         PSF_OFF_CTRL: rd_mux = {31'h0000_0000, rel21_reg};
         PSF_OFF_INFO: rd_mux = {8'h00, fault_base_reg, 1'b0,
            fatal_reg, refused_reg, busy_reg,
            fault_area_reg, handling_reg};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hrdata_reg <= PSF_WORD_RST;
      end else if (rd_pend_reg) begin
         hrdata_reg <= rd_mux;
      end
   end

   // plain storage registers
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pid_reg <= PSF_PID_RST;
         length_reg <= 16'h0000;
         objidx_reg <= 16'h0000;
         domain_reg <= PSF_WORD_RST;
         rel21_reg <= 1'b0;
      end else if (wr_now) begin
         case (addr_reg)
            PSF_OFF_PID: pid_reg <= {i_hwdata[15:PSF_PID_LO_W],
               {PSF_PID_LO_W{1'b0}}};
            PSF_OFF_LENGTH: length_reg <= i_hwdata[15:0];
            PSF_OFF_OBJIDX: objidx_reg <= i_hwdata[15:0];
            PSF_OFF_DOMAIN: domain_reg <= i_hwdata;
            PSF_OFF_CTRL: rel21_reg <= i_hwdata[PSF_CTRL_REL21];
            default: ;
         endcase
      end
   end

   // status word; hardware sets win over software writes
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         status_reg <= PSF_STATUS_RST;
      end else begin
         // opaque bits are only stored, never acted on
         if (wr_now && addr_reg == PSF_OFF_STATUS) begin
            status_reg <= i_hwdata[15:0];
         end
         if (i_attach) begin
            status_reg[PSF_ST_BOUND] <= 1'b1;
         end else if (i_detach) begin
            status_reg[PSF_ST_BOUND] <= 1'b0;
         end
         if (fault_wr_reg && fault_area_reg == PSF_SEV_CTX) begin
            status_reg[PSF_ST_CTXF] <= 1'b1;
         end
         if (fault_wr_reg && fault_area_reg == PSF_SEV_PROC) begin
            status_reg[PSF_ST_PROCF] <= 1'b1;
         end
      end
   end

   // function sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSF_S_IDLE: begin
            if (func_ok) begin
               state_next = PSF_S_BUSY;
            end
         end
         PSF_S_BUSY: begin
            if (i_func_done) begin
               state_next = PSF_S_IDLE;
            end
         end
         PSF_S_HALT: state_next = PSF_S_HALT;
         default: state_next = PSF_S_IDLE;
      endcase
      if (fatal_reg) begin
         state_next = PSF_S_HALT;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= PSF_S_IDLE;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         busy_reg <= state_next == PSF_S_BUSY;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         host_reg <= 16'h0000;
         host_valid_reg <= 1'b0;
         func_start_reg <= 1'b0;
         env_switch_reg <= 1'b0;
      end else begin
         func_start_reg <= func_ok;
         env_switch_reg <= 1'b0;
         if (func_ok) begin
            // new requester: expose its interface process environment
            if (!host_valid_reg || host_reg != i_hwdata[15:0]) begin
               env_switch_reg <= 1'b1;
            end
            host_reg <= i_hwdata[15:0];
            host_valid_reg <= 1'b1;
         end
      end
   end

   // refused request flag; a new refusal wins over the clear
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         refused_reg <= 1'b0;
      end else if (func_go && !func_ok) begin
         refused_reg <= 1'b1;
      end else if (clrerr_wr) begin
         refused_reg <= 1'b0;
      end
   end

   // fault severity and area resolution
   assign fin.sev = i_fault_valid ? i_fault_sev : PSF_SEV_NONE;
   assign fin.handling = handling_reg;
   assign fin.bound = status_reg[PSF_ST_BOUND];
   assign fin.ctx_faulted = status_reg[PSF_ST_CTXF];
   assign fin.fvec = status_reg[PSF_ST_FVEC];
   assign fin.rel21 = rel21_reg;

   psf_fault_sel u_fault_sel (
      .i_req(fin),
      .o_res(fout)
   );

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fault_wr_reg <= 1'b0;
         fault_area_reg <= PSF_SEV_NONE;
         fault_base_reg <= 16'h0000;
      end else begin
         fault_wr_reg <= 1'b0;
         // a second processor fault records nothing and goes fatal
         if (fout.eff_sev != PSF_SEV_NONE && !fatal_reg
               && handling_reg != PSF_SEV_CPU) begin
            fault_wr_reg <= 1'b1;
            fault_area_reg <= fout.area;
            fault_base_reg <= area_base(fout.area);
         end
      end
   end

   // level now being handled; a new fault wins over the acknowledge
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         handling_reg <= PSF_SEV_NONE;
         fatal_reg <= 1'b0;
      end else begin
         if (fout.eff_sev != PSF_SEV_NONE) begin
            if (handling_reg == PSF_SEV_CPU) begin
               fatal_reg <= 1'b1;
            end else begin
               handling_reg <= fout.eff_sev;
            end
         end else if (fack_wr) begin
            handling_reg <= PSF_SEV_NONE;
         end
      end
   end

   assign o_hrdata = hrdata_reg;
   assign o_hreadyout = hreadyout_reg;
   assign o_hresp = hresp_reg;
   assign o_func_start = func_start_reg;
   assign o_func_host = host_reg;
   assign o_env_switch = env_switch_reg;
   assign o_proc_id = pid_reg;
   assign o_fault_wr = fault_wr_reg;
   assign o_fault_area = fault_area_reg;
   assign o_fault_base = fault_base_reg;
   assign o_fatal = fatal_reg;
   assign o_bound = status_reg[PSF_ST_BOUND];
   assign o_busy = busy_reg;

endmodule

/* File: verif/psf_top_assertions.sv */
/*
 * psf_top_chk: port-level assertions for psf_top, bound after endmodule.
 * assumes: single clock, async active-low reset, hreadyout is hready.
 */
`timescale 1ns/1ps
module psf_top_chk (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // bus
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // process and function
   input wire logic i_attach,
   input wire logic i_detach,
   input wire logic o_func_start,
   input wire logic o_env_switch,
   input wire logic [15:0] o_proc_id,
   input wire logic o_bound,
   input wire logic o_busy,
   // faults
   input wire logic i_fault_valid,
   input wire logic o_fault_wr,
   input wire psf_pkg::psf_sev_t o_fault_area,
   input wire logic [15:0] o_fault_base,
   input wire logic o_fatal
);
   import psf_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   resp_okay_a: assert property (!o_hresp)
      else $error("bus response not okay");
   read_wait_a: assert property (i_hsel && i_htrans[1] && i_hready &&
      !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read wait state wrong");
   pid_low_a: assert property (o_proc_id[1:0] == 2'h0)
      else $error("process id low bits not zero");
   attach_bound_a: assert property (i_attach |=> o_bound)
      else $error("bound not set on attach");
   detach_bound_a: assert property (i_detach && !i_attach |=> !o_bound)
      else $error("bound not cleared on detach");
   start_pulse_a: assert property (o_func_start |=> !o_func_start)
      else $error("start longer than one cycle");
   start_idle_a: assert property (o_func_start |-> o_busy && !$past(o_busy))
      else $error("start while busy");
   env_with_start_a: assert property (o_env_switch |-> o_func_start)
      else $error("switch without start");
   wr_cause_a: assert property (o_fault_wr |-> $past(i_fault_valid))
      else $error("record write without fault");
   area_base_a: assert property (o_fault_wr |-> o_fault_base ==
      (o_fault_area == PSF_SEV_CTX ? PSF_CTX_AREA_BASE :
      o_fault_area == PSF_SEV_PROC ? PSF_PROC_AREA_BASE : PSF_CPU_AREA_BASE))
      else $error("area base mismatch");
   unbound_area_a: assert property (i_fault_valid && !o_bound |=>
      !o_fault_wr || o_fault_area != PSF_SEV_PROC)
      else $error("process area used while unbound");
   fatal_sticky_a: assert property (o_fatal |=> o_fatal)
      else $error("fatal dropped");
   fatal_quiet_a: assert property ($rose(o_fatal) |-> !o_fault_wr)
      else $error("record written on fatal");
   cover property (o_func_start && o_env_switch);
   cover property (o_fault_wr && o_fault_area == PSF_SEV_CTX);
   cover property ($rose(o_fatal));
endmodule

bind psf_top psf_top_chk chk (.*);

/* File: verif/psf_engine_model.sv */
/*
 * psf_engine_model: function engine that ends each started function.
 * assumes: delay of one or more cycles, held while a function runs.
 */
`timescale 1ns/1ps
module psf_engine_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // start and run length
   input wire logic i_start,
   input wire logic [7:0] i_delay,
   // completion pulse
   output logic o_done
);
   logic [7:0] cnt_reg;
   // one done per start, so functions stay single
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_reg <= 8'h00;
         o_done <= 1'b0;
      end else begin
         o_done <= (cnt_reg == 8'h01);
         if (i_start)
            cnt_reg <= i_delay;
         else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule

/* File: verif/tb_psf_top.sv */
/*
 * tb_psf_top: self-checking bench for psf_top with an engine model.
 * assumes: hready is looped from hreadyout; 25 MHz clock.
 */
`timescale 1ns/1ps
module tb_psf_top;
   import psf_pkg::*;
   logic i_clock, i_rst_b, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd, w;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic i_attach, i_detach, i_func_done, o_func_start, o_env_switch;
   logic [15:0] o_func_host, o_proc_id, o_fault_base, prev;
   logic i_fault_valid, o_fault_wr, o_fatal, o_bound, o_busy;
   psf_sev_t i_fault_sev, o_fault_area;
   logic [7:0] delay;
   logic [7:0] offs[6] = '{PSF_OFF_LENGTH, PSF_OFF_OBJIDX, PSF_OFF_PID,
      PSF_OFF_DOMAIN, 8'h20, 8'hfc};
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   int seed = 32'hb2674069;
   assign i_hready = o_hreadyout;
   psf_top dut (.*);
   psf_engine_model eng (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_start(o_func_start), .i_delay(delay), .o_done(i_func_done));
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hang guard; the run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   function automatic logic [31:0] expect_rd(logic [7:0] a, logic [31:0] d);
      case (a)
         PSF_OFF_LENGTH: return 32'(d[15:0]) + 32'h1;
         PSF_OFF_OBJIDX: return 32'(d[15:2]);
         PSF_OFF_PID: return {16'h0, d[15:2], 2'h0};
         PSF_OFF_DOMAIN: return d;
         default: return 32'h0;
      endcase
   endfunction
   function automatic logic [15:0] base_of(psf_sev_t a);
      return 16'h0020 * 16'(a) + 16'h0020;
   endfunction
   task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge i_clock);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_haddr <= {24'h0, a};
      do @(posedge i_clock); while (i_hready !== 1'b1);
      i_htrans <= 2'h0;
      i_hsel <= 1'b0;
      i_hwdata <= d;
      do @(posedge i_clock); while (i_hready !== 1'b1);
      rd = o_hrdata;
   endtask
   task automatic rdchk(string n, logic [7:0] a, logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task automatic evt(logic at);
      @(posedge i_clock);
      i_attach <= at;
      i_detach <= !at;
      @(posedge i_clock);
      i_attach <= 1'b0;
      i_detach <= 1'b0;
      #1;
      chk("bound", 32'(at), 32'(o_bound));
   endtask
   task automatic flt(psf_sev_t s, psf_sev_t ea);
      @(posedge i_clock);
      i_fault_valid <= 1'b1;
      i_fault_sev <= s;
      @(posedge i_clock);
      i_fault_valid <= 1'b0;
      #1;
      chk("fault_wr", 32'(ea != PSF_SEV_NONE), 32'(o_fault_wr));
      if (ea != PSF_SEV_NONE) begin
         chk("area", 32'(ea), 32'(o_fault_area));
         chk("base", 32'(base_of(ea)), 32'(o_fault_base));
      end else
         chk("fatal", 32'h1, 32'(o_fatal));
   endtask
   initial begin
      i_rst_b = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'h0;
      i_hwrite = 1'b0;
      i_hsize = 3'h2;
      i_hwdata = 32'h0;
      i_attach = 1'b0;
      i_detach = 1'b0;
      i_fault_valid = 1'b0;
      i_fault_sev = PSF_SEV_NONE;
      delay = 8'h01;
      repeat (6) @(posedge i_clock);
      i_rst_b <= 1'b1;
      rdchk("status", PSF_OFF_STATUS, 32'h0);
      rdchk("info", PSF_OFF_INFO, 32'h0);
      $display("test reset done");
      foreach (offs[i]) begin
         w = $random(seed);
         ahb(1'b1, offs[i], w);
         rdchk("field", offs[i], expect_rd(offs[i], w));
         if (offs[i] == PSF_OFF_PID)
            chk("proc_id", expect_rd(offs[i], w), 32'(o_proc_id));
      end
      $display("test fields done");
      // not ready yet: request must bounce
      ahb(1'b1, PSF_OFF_FUNC, 32'h0001_0000);
      #1;
      chk("start", 32'h0, 32'(o_func_start));
      rdchk("refused", PSF_OFF_INFO, 32'h20);
      ahb(1'b1, PSF_OFF_CTRL, 32'h4);
      ahb(1'b1, PSF_OFF_STATUS, 32'hab08);
      rdchk("opaque", PSF_OFF_STATUS, 32'hab08);
      prev = 16'($random(seed));
      for (int k = 0; k < 3; k++) begin
         w = {15'h0, 1'b1, (k == 2) ? ~prev : prev};
         delay <= (k == 1) ? 8'h14 : 8'($random(seed)) % 8'h04 + 8'h01;
         ahb(1'b1, PSF_OFF_FUNC, w);
         #1;
         chk("start", 32'h1, 32'(o_func_start));
         chk("switch", 32'(k != 1), 32'(o_env_switch));
         chk("host", 32'(w[15:0]), 32'(o_func_host));
         if (k == 1) begin
            ahb(1'b1, PSF_OFF_FUNC, w);
            rdchk("busy", PSF_OFF_INFO, 32'h30);
            ahb(1'b1, PSF_OFF_CTRL, 32'h4);
         end
         while (o_busy !== 1'b0) @(posedge i_clock);
      end
      rdchk("func", PSF_OFF_FUNC, {15'h0, 1'b1, ~prev});
      $display("test functions done");
      evt(1'b1);
      flt(PSF_SEV_PROC, PSF_SEV_PROC);
      rdchk("st_proc", PSF_OFF_STATUS, 32'hab0d);
      ahb(1'b1, PSF_OFF_CTRL, 32'h2);
      evt(1'b0);
      flt(PSF_SEV_PROC, PSF_SEV_CPU);
      ahb(1'b1, PSF_OFF_CTRL, 32'h2);
      evt(1'b1);
      flt(PSF_SEV_CTX, PSF_SEV_CTX);
      rdchk("st_ctx", PSF_OFF_STATUS, 32'hab0f);
      flt(PSF_SEV_CTX, PSF_SEV_PROC);
      ahb(1'b1, PSF_OFF_CTRL, 32'h2);
      ahb(1'b1, PSF_OFF_STATUS, 32'h19);
      ahb(1'b1, PSF_OFF_CTRL, 32'h3);
      flt(PSF_SEV_PROC, PSF_SEV_CTX);
      ahb(1'b1, PSF_OFF_CTRL, 32'h3);
      flt(PSF_SEV_PROC, PSF_SEV_CPU);
      flt(PSF_SEV_CTX, PSF_SEV_NONE);
      rdchk("info_end", PSF_OFF_INFO, 32'h804f);
      $display("test faults done");
      tally_and_finish();
   end
endmodule
